// File: rtl/drive_ctl_defs.svh
`ifndef DRIVE_CTL_DEFS_SVH
`define DRIVE_CTL_DEFS_SVH
`define REG_COMMAND 16'hC350
`define REG_SETPOINT 16'hC35A
`define REG_STATUS 16'hC418
`define REG_FREQUENCY 16'hC422
`define PERCENT_FULL 16'h4000
`define CMD_RESET 16'h0000
`define SETPOINT_RESET 16'h0000
`define CB_PRESET 1:0
`define CB_BRAKE 2
`define CB_COAST 3
`define CB_QSTOP 4
`define CB_HOLD 5
`define CB_START 6
`define CB_TRIPRST 7
`define CB_JOG 8
`define CB_RAMP 9
`define CB_VALID 10
`define CB_RELAY1 11
`define CB_RELAY2 12
`define CB_SETUP 13
`define CB_REVERSE 15
`define SB_CTRLRDY 0
`define SB_DRVRDY 1
`define SB_ENABLE 2
`define SB_TRIP 3
`define SB_ERROR 4
`define SB_UNUSED 5
`define SB_LOCK 6
`define SB_WARN 7
`define SB_ATREF 8
`define SB_BUS 9
`define SB_INLIM 10
`define SB_RUN 11
`define SB_OTEMP 12
`define SB_VOLT 13
`define SB_CURR 14
`define SB_TIMER 15
`endif

// File: rtl/drive_ctl_pkg.sv
package drive_ctl_pkg;
  typedef enum logic [1:0] {
    REV_DIGITAL = 2'h0,
    REV_BUS = 2'h1,
    REV_AND = 2'h2,
    REV_OR = 2'h3
  } rev_src_t;
  typedef struct packed {
    logic tripped;
    logic tripLocked;
    logic errorNoTrip;
    logic warning;
    logic atReference;
    logic localOff;
    logic refLocal;
    logic inLimits;
    logic overTemp;
    logic dcVoltBad;
    logic currentOver;
    logic timerOver;
  } drive_state_t;
  typedef struct packed {
    logic invBrake;
    logic invCoast;
    logic invCoastReset;
    logic speedUp;
    logic slowDown;
    logic reverse;
  } din_t;
  typedef struct packed {
    logic [1:0] presetSel;
    logic brakeStop;
    logic coast;
    logic quickStop;
    logic holdFreq;
    logic rampStop;
    logic jog;
    logic rampPair;
    logic relay1;
    logic relay2;
    logic setupSel;
    logic reverse;
    logic tripReset;
  } drive_cmd_t;
endpackage

// File: rtl/edge_rise_detect.sv
`timescale 1ns/1ps
module edge_rise_detect (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Level and qualifier
  input wire logic level,
  input wire logic sample,
  // Rising pulse
  output logic rise
);
  logic prev_q;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prev_q <= 1'b0;
    end else if (sample) begin
      prev_q <= level;
    end
  end

  assign rise = sample & level & ~prev_q;
endmodule

// File: rtl/drive_control_status_word.sv
`timescale 1ns/1ps
`include "drive_ctl_defs.svh"
module drive_control_status_word #(
  parameter int WORD_W = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regAddr,
  input wire logic [WORD_W-1:0] regWdata,
  output logic [WORD_W-1:0] regRdata,
  output logic regAck,
  // Configuration
  input wire logic relay1IsBit,
  input wire logic relay2IsBit,
  input wire logic multiSetup,
  input wire drive_ctl_pkg::rev_src_t revSource,
  // Drive state and inputs
  input wire drive_ctl_pkg::drive_state_t driveState,
  input wire drive_ctl_pkg::din_t digIn,
  input wire logic [WORD_W-1:0] outFrequency,
  // Decoded commands
  output drive_ctl_pkg::drive_cmd_t cmdOut,
  output logic outputOff,
  output logic freezeActive,
  output logic [WORD_W-1:0] speedSetpoint
);
  logic [WORD_W-1:0] cmdWord_q;
  logic [WORD_W-1:0] setpoint_q;
  logic [WORD_W-1:0] status_q;
  logic [WORD_W-1:0] status_d;
  logic [WORD_W-1:0] freq_q;
  logic writeCmd;
  logic validWrite;
  logic resetRise;
  logic resetRise_q;
  logic frozenStop;
  logic revAllowed;
  drive_ctl_pkg::drive_cmd_t cmd_d;

  ////////////////////////////////////////////////////////////////
  // Register writes
  assign writeCmd = regWrite && regAddr == `REG_COMMAND;
  assign validWrite = writeCmd && regWdata[`CB_VALID];

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cmdWord_q <= `CMD_RESET;
    end else if (validWrite) begin
      cmdWord_q <= regWdata;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      setpoint_q <= `SETPOINT_RESET;
      speedSetpoint <= `SETPOINT_RESET;
    end else begin
      if (regWrite && regAddr == `REG_SETPOINT) begin
        setpoint_q <= regWdata;
      end
      speedSetpoint <= setpoint_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Trip reset edge
  edge_rise_detect resetEdge (
    .clock(clock),
    .sys_rst(sys_rst),
    .level(regWdata[`CB_TRIPRST]),
    .sample(validWrite),
    .rise(resetRise)
  );

  // Align trip reset pulse with decoded word
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      resetRise_q <= 1'b0;
    end else begin
      resetRise_q <= resetRise;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Command decode
  assign revAllowed = revSource == drive_ctl_pkg::REV_BUS
    || (revSource == drive_ctl_pkg::REV_AND && digIn.reverse)
    || revSource == drive_ctl_pkg::REV_OR;
  assign frozenStop = ~cmdWord_q[`CB_COAST] || ~cmdWord_q[`CB_BRAKE]
    || digIn.invBrake || digIn.invCoast || digIn.invCoastReset;

  always_comb begin
    cmd_d.presetSel = cmdWord_q[`CB_PRESET];
    cmd_d.brakeStop = ~cmdWord_q[`CB_BRAKE];
    cmd_d.coast = ~cmdWord_q[`CB_COAST];
    cmd_d.holdFreq = ~cmdWord_q[`CB_HOLD];
    cmd_d.quickStop = ~cmdWord_q[`CB_QSTOP] && ~cmd_d.holdFreq;
    cmd_d.rampStop = ~cmdWord_q[`CB_START] && ~cmd_d.holdFreq;
    cmd_d.jog = cmdWord_q[`CB_JOG];
    cmd_d.rampPair = cmdWord_q[`CB_RAMP];
    cmd_d.relay1 = cmdWord_q[`CB_RELAY1] && relay1IsBit;
    cmd_d.relay2 = cmdWord_q[`CB_RELAY2] && relay2IsBit;
    cmd_d.setupSel = cmdWord_q[`CB_SETUP] && multiSetup;
    cmd_d.reverse = revSource == drive_ctl_pkg::REV_OR
      ? (cmdWord_q[`CB_REVERSE] || digIn.reverse)
      : (cmdWord_q[`CB_REVERSE] && revAllowed);
    cmd_d.tripReset = resetRise_q;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cmdOut <= '0;
      outputOff <= 1'b1;
      freezeActive <= 1'b0;
    end else begin
      cmdOut <= cmd_d;
      outputOff <= ~cmdWord_q[`CB_COAST] || digIn.invCoast
        || digIn.invCoastReset;
      freezeActive <= cmd_d.holdFreq && ~frozenStop;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Status word
  always_comb begin
    status_d = '0;
    status_d[`SB_CTRLRDY] = ~driveState.tripped;
    status_d[`SB_DRVRDY] = ~driveState.tripped && ~driveState.tripLocked;
    status_d[`SB_ENABLE] = cmdWord_q[`CB_COAST] && ~digIn.invCoast;
    status_d[`SB_TRIP] = driveState.tripped;
    status_d[`SB_ERROR] = driveState.errorNoTrip;
    status_d[`SB_LOCK] = driveState.tripLocked;
    status_d[`SB_WARN] = driveState.warning;
    status_d[`SB_ATREF] = driveState.atReference;
    status_d[`SB_BUS] = ~driveState.localOff && ~driveState.refLocal;
    status_d[`SB_INLIM] = driveState.inLimits;
    status_d[`SB_RUN] = cmdWord_q[`CB_START] && status_d[`SB_ENABLE]
      && ~driveState.tripped;
    status_d[`SB_OTEMP] = driveState.overTemp;
    status_d[`SB_VOLT] = driveState.dcVoltBad;
    status_d[`SB_CURR] = driveState.currentOver;
    status_d[`SB_TIMER] = driveState.timerOver;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      status_q <= '0;
      freq_q <= '0;
    end else begin
      status_q <= status_d;
      freq_q <= outFrequency;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Register reads
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      regRdata <= '0;
      regAck <= 1'b0;
    end else begin
      regAck <= regRead || regWrite;
      if (regRead) begin
        unique case (regAddr)
          `REG_COMMAND: regRdata <= cmdWord_q;
          `REG_SETPOINT: regRdata <= setpoint_q;
          `REG_STATUS: regRdata <= status_q;
          `REG_FREQUENCY: regRdata <= freq_q;
          default: regRdata <= '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks
  invalid_ignored_a: assert property (@(posedge clock) disable iff (sys_rst)
    (writeCmd && !regWdata[`CB_VALID]) |=> $stable(cmdWord_q))
    else $error("command accepted without valid bit");
  trip_edge_a: assert property (@(posedge clock) disable iff (sys_rst)
    resetRise |-> validWrite && regWdata[`CB_TRIPRST])
    else $error("trip reset without write of bit");
  trip_pulse_a: assert property (@(posedge clock) disable iff (sys_rst)
    cmdOut.tripReset |=> !cmdOut.tripReset)
    else $error("trip reset longer than one cycle");
  coast_off_a: assert property (@(posedge clock) disable iff (sys_rst)
    (validWrite && !regWdata[`CB_COAST]) |=> ##1 outputOff)
    else $error("coast did not disable output");
  brake_cmd_a: assert property (@(posedge clock) disable iff (sys_rst)
    (validWrite && !regWdata[`CB_BRAKE]) |=> ##1 cmdOut.brakeStop)
    else $error("brake not decoded");
  preset_sel_a: assert property (@(posedge clock) disable iff (sys_rst)
    validWrite |=> ##1 cmdOut.presetSel == $past(regWdata[`CB_PRESET], 2))
    else $error("preset select mismatch");
  quick_stop_a: assert property (@(posedge clock) disable iff (sys_rst)
    !$past(sys_rst) |-> cmdOut.quickStop
      == $past(!cmdWord_q[`CB_QSTOP] && cmdWord_q[`CB_HOLD]))
    else $error("quick stop mismatch");
  hold_freq_a: assert property (@(posedge clock) disable iff (sys_rst)
    !$past(sys_rst) |-> cmdOut.holdFreq == $past(!cmdWord_q[`CB_HOLD]))
    else $error("hold mismatch");
  freeze_stop_a: assert property (@(posedge clock) disable iff (sys_rst)
    freezeActive |-> $past(!frozenStop))
    else $error("freeze kept despite stop source");
  ramp_stop_a: assert property (@(posedge clock) disable iff (sys_rst)
    !$past(sys_rst) |-> cmdOut.rampStop
      == $past(!cmdWord_q[`CB_START] && cmdWord_q[`CB_HOLD]))
    else $error("ramp stop mismatch");
  jog_sel_a: assert property (@(posedge clock) disable iff (sys_rst)
    !$past(sys_rst) |-> cmdOut.jog == $past(cmdWord_q[`CB_JOG]))
    else $error("jog mismatch");
  ramp_pair_a: assert property (@(posedge clock) disable iff (sys_rst)
    !$past(sys_rst) |-> cmdOut.rampPair == $past(cmdWord_q[`CB_RAMP]))
    else $error("ramp pair mismatch");
  relay_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
    cmdOut.relay1 |-> $past(relay1IsBit))
    else $error("relay 1 driven while unconfigured");
  relay_two_a: assert property (@(posedge clock) disable iff (sys_rst)
    cmdOut.relay2 |-> $past(relay2IsBit))
    else $error("relay 2 driven while unconfigured");
  setup_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
    cmdOut.setupSel |-> $past(multiSetup))
    else $error("set-up selected while single set-up");
  reverse_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
    $past(revSource == drive_ctl_pkg::REV_DIGITAL) |-> !cmdOut.reverse)
    else $error("reverse under digital source");
  setpoint_copy_a: assert property (@(posedge clock) disable iff (sys_rst)
    !$past(sys_rst) |-> speedSetpoint == $past(setpoint_q))
    else $error("setpoint output mismatch");
  status_reg_a: assert property (@(posedge clock) disable iff (sys_rst)
    !$past(sys_rst) |-> status_q == $past(status_d))
    else $error("status not registered");
  status_trip_a: assert property (@(posedge clock) disable iff (sys_rst)
    $past(driveState.tripped) |-> status_q[`SB_TRIP] && !status_q[`SB_CTRLRDY])
    else $error("trip not shown in status");
  status_reserved_a: assert property (@(posedge clock) disable iff (sys_rst)
    status_q[`SB_UNUSED] == 1'b0)
    else $error("unused status bit set");
  status_enable_a: assert property (@(posedge clock) disable iff (sys_rst)
    $past(!cmdWord_q[`CB_COAST]) |-> !status_q[`SB_ENABLE])
    else $error("enable shown while coasting");
  status_run_a: assert property (@(posedge clock) disable iff (sys_rst)
    status_q[`SB_RUN] |-> status_q[`SB_ENABLE])
    else $error("running shown without enable");
  bus_ctrl_a: assert property (@(posedge clock) disable iff (sys_rst)
    $past(driveState.refLocal) |-> !status_q[`SB_BUS])
    else $error("bus control shown while local");
  ack_pulse_a: assert property (@(posedge clock) disable iff (sys_rst)
    (regRead || regWrite) |=> regAck)
    else $error("access not acknowledged");
  read_status_a: assert property (@(posedge clock) disable iff (sys_rst)
    (regRead && regAddr == `REG_STATUS) |=> regRdata == $past(status_q))
    else $error("status read mismatch");
endmodule

// File: testbench/bus_master_model.sv
`timescale 1ns/1ps
module bus_master_model (
  // Clock
  input wire logic clock,
  // Register port
  output logic regWrite,
  output logic regRead,
  output logic [15:0] regAddr,
  output logic [15:0] regWdata,
  input wire logic [15:0] regRdata,
  input wire logic regAck
);
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 16'h0000;
    regWdata = 16'h0000;
  end
  ////////////////////
  // One access, strobe one cycle, answer within four cycles
  task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d,
      output logic [15:0] rd, output logic ok);
    int n;
    @(negedge clock);
    regWrite = wr;
    regRead = !wr;
    regAddr = a;
    regWdata = d;
    @(negedge clock);
    ok = regAck;
    rd = regRdata;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = ~a;
    regWdata = ~d;
    for (n = 0; n < 3 && !ok; n++) begin
      @(negedge clock);
      ok = regAck;
      rd = regRdata;
    end
  endtask
endmodule

// File: testbench/drive_control_status_word_tb.sv
`timescale 1ns/1ps
`include "drive_ctl_defs.svh"
module drive_control_status_word_tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic r1 = 1'b0;
  logic r2 = 1'b0;
  logic ms = 1'b0;
  logic [15:0] freq = 16'h0000;
  logic [15:0] regAddr, regWdata, regRdata, speedSetpoint, rd, cw, v;
  logic [15:0] last = 16'h0000;
  logic regWrite, regRead, regAck, outputOff, freezeActive, ok, p7;
  drive_ctl_pkg::rev_src_t rev = drive_ctl_pkg::REV_DIGITAL;
  drive_ctl_pkg::drive_state_t ds = '0;
  drive_ctl_pkg::din_t din = '0;
  drive_ctl_pkg::drive_cmd_t cmdOut;
  int mismatches = 0;
  int check_count = 0;
  int cyc = 0;
  int i;
  drive_control_status_word u_drive_control_status_word (.clock(clock), .sys_rst(sys_rst),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata), .regAck(regAck), .relay1IsBit(r1), .relay2IsBit(r2),
    .multiSetup(ms), .revSource(rev), .driveState(ds), .digIn(din), .outFrequency(freq),
    .cmdOut(cmdOut), .outputOff(outputOff), .freezeActive(freezeActive),
    .speedSetpoint(speedSetpoint));
  bus_master_model u_master (.clock(clock), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regAck(regAck));
  always #4 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      mismatches++;
      close_out();
    end
  end
  ////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
    u_master.access(w, a, d, rd, ok);
    chk({15'h0000, ok}, 16'h0001, "no answer");
    if (w && a == `REG_COMMAND && d[10]) begin
      last = d;
    end
  endtask
  function automatic logic [15:0] expCmd(input logic [15:0] c, input logic tr);
    drive_ctl_pkg::drive_cmd_t e;
    e.presetSel = c[1:0];
    e.brakeStop = ~c[2];
    e.coast = ~c[3];
    e.holdFreq = ~c[5];
    e.quickStop = ~c[4] & c[5];
    e.rampStop = ~c[6] & c[5];
    e.jog = c[8];
    e.rampPair = c[9];
    e.relay1 = c[11] & r1;
    e.relay2 = c[12] & r2;
    e.setupSel = c[13] & ms;
    e.tripReset = tr;
    case (rev)
      drive_ctl_pkg::REV_BUS: e.reverse = c[15];
      drive_ctl_pkg::REV_AND: e.reverse = c[15] & din.reverse;
      drive_ctl_pkg::REV_OR: e.reverse = c[15] | din.reverse;
      default: e.reverse = 1'b0;
    endcase
    return 16'(e);
  endfunction
  function automatic logic [15:0] expStatus();
    logic en;
    logic run;
    en = last[3] & ~din.invCoast;
    run = last[6] & en & ~ds.tripped;
    return {ds.timerOver, ds.currentOver, ds.dcVoltBad, ds.overTemp, run, ds.inLimits,
      ~(ds.localOff | ds.refLocal), ds.atReference, ds.warning, ds.tripLocked, 1'b0,
      ds.errorNoTrip, ds.tripped, en, ~(ds.tripped | ds.tripLocked), ~ds.tripped};
  endfunction
  task automatic chkCmd(input logic tr);
    @(negedge clock);
    chk(16'(cmdOut), expCmd(last, tr), "command decode");
    chk({15'h0000, outputOff}, {15'h0000, ~last[3]}, "output stage");
    chk({15'h0000, freezeActive}, {15'h0000, ~last[5] & last[3] & last[2] & ~din.invBrake},
      "freeze");
  endtask
  ////////////////////
  initial begin
    void'($urandom(30));
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    chk(16'(cmdOut), 16'h0000, "command outputs at reset");
    chk({15'h0000, outputOff}, 16'h0001, "output stage at reset");
    acc(1'b0, `REG_COMMAND, 16'h0000);
    chk(rd, 16'h0000, "command word at reset");
    $display("test reset done");
    for (i = 0; i < 48; i++) begin
      r1 = 1'($urandom);
      r2 = 1'($urandom);
      ms = 1'($urandom);
      rev = drive_ctl_pkg::rev_src_t'(i % 4);
      din.reverse = 1'($urandom) & (i % 4 != 0);
      ds = 12'($urandom);
      ds.tripLocked = ds.tripLocked & ds.tripped;
      freq = 16'($urandom);
      cw = 16'($urandom);
      if (i % 5 == 0) begin
        cw[10] = 1'b0;
      end
      p7 = last[7];
      acc(1'b1, `REG_COMMAND, cw);
      chkCmd(cw[10] & cw[7] & ~p7);
      acc(1'b0, `REG_STATUS, 16'h0000);
      chk(rd, expStatus(), "status word");
      acc(1'b0, `REG_FREQUENCY, 16'h0000);
      chk(rd, freq, "actual frequency");
      v = 16'($urandom);
      acc(1'b1, `REG_SETPOINT, v);
      @(negedge clock);
      chk(speedSetpoint, v, "setpoint out");
      acc(1'b0, `REG_SETPOINT, 16'h0000);
      chk(rd, v, "setpoint readback");
    end
    $display("test random done");
    acc(1'b1, `REG_COMMAND, 16'h040C);
    chkCmd(1'b0);
    din.invBrake = 1'b1;
    chkCmd(1'b0);
    din.invBrake = 1'b0;
    acc(1'b1, `REG_COMMAND, 16'h04CC);
    chkCmd(1'b1);
    chkCmd(1'b0);
    acc(1'b1, `REG_COMMAND, 16'h04CC);
    chkCmd(1'b0);
    acc(1'b1, `REG_STATUS, 16'hFFFF);
    acc(1'b0, `REG_STATUS, 16'h0000);
    chk(rd, expStatus(), "status not writable");
    acc(1'b0, 16'h0000, 16'h0000);
    chk(rd, 16'h0000, "unmapped read");
    $display("test corners done");
    close_out();
  end
endmodule
